/* File: rtl/rss_top.sv */
// Purpose: Reset sequencer combining supply monitors, pin and software resets.
// Assumes: Monitor inputs are asynchronous levels, high while supply is low.
// Notes:   Registers over AXI4-Lite; answers come one cycle after acceptance.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

// How it works
// - Reset holds registers, tristates ports, vector zero.
// - Five sources merge into internal reset.
// - Power-on reset held while supply low.
// - Fixed 143 us initialization after threshold.
// - Hold reset until start-up timer finishes.
// - Supply dropping reasserts power-on reset immediately.
// - Cold start sets power-off flag.
// - Low reset pin extends internal reset.
// - With brown-out, timer waits for supply and init.
// - RC/external clock delays 16/512/1024/4096 us.
// - Crystal delays 1024/2048/4096/16384 us.
// - Same delay after brown-out and wake-up.
// - Brown-out asserts reset immediately.
// - Brown-out recovery releases after start-up delay.
// - Brown-out ignored unless its fuse set.
module rss_top
	import rss_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Supply monitors and pin (asynchronous)
	input  wire logic        por_low,
	input  wire logic        brownout_detector,
	input  wire logic        reset_pin_n,
	// Configuration fuses
	input  wire rss_fuse_s   fuses,
	// Wake-up from power-down in internally timed mode
	input  wire logic        wake_req,
	// Reset outputs
	output logic             sys_reset,
	output logic             port_oe_n,
	output logic [15:0]      pc_start,
	// AXI4-Lite write address
	input  wire logic [3:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);

	// ==========================================================================
	// Input synchronisation
	// ==========================================================================
	rss_mon_s mon_raw;
	rss_mon_s mon;

	assign mon_raw = '{por_low: por_low, brn_low: brownout_detector, pin_low: !reset_pin_n};

	rss_sync #(.WIDTH(3)) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in (mon_raw),
		.sync_out (mon)
	);

	// ==========================================================================
	// Microsecond time base
	// ==========================================================================
	logic [5:0] div_r;
	logic [5:0] div_nxt;
	logic       tick;

	// Fixed time base keeps delays independent of fuse changes.
	always_comb begin
		tick    = (div_r == 6'(US_TICK_CYCLES - 1));
		div_nxt = tick ? 6'h00 : div_r + 6'h01;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= 6'h00;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ==========================================================================
	// Sequencer
	// ==========================================================================
	rss_state_e  state_r;
	rss_state_e  state_nxt;
	logic [12:0] init_r;
	logic [12:0] init_nxt;
	logic        brn_act;
	logic        timer_run;
	logic        timer_done;
	logic        cold_r;
	logic        cold_nxt;
	logic [4:0]  pulse_r;
	logic [4:0]  pulse_nxt;
	logic        sw_req;
	logic        wd_req;

	// Brown-out counts only when its fuse is programmed.
	assign brn_act   = fuses.brn_en && mon.brn_low;
	// Timer counts only in START; brown-out must be clear first.
	assign timer_run = (state_r == RSS_ST_START) && !brn_act;

	rss_startup_timer u_timer (
		.clk                (clk),
		.resetn             (resetn),
		.run                (timer_run),
		.tick               (tick),
		.xtal               (fuses.xtal),
		.startup_time_fuses (fuses.startup_time_fuses),
		.done               (timer_done)
	);

	// Supply faults force RESET from any state without delay.
	always_comb begin
		state_nxt = state_r;
		init_nxt  = init_r;
		cold_nxt  = cold_r;
		case (state_r)
			RSS_ST_RESET: begin
				init_nxt = '0;
				if (!mon.por_low) begin
					state_nxt = cold_r ? RSS_ST_INIT : RSS_ST_START;
				end
			end
			RSS_ST_INIT: begin
				if (init_r == 13'(INIT_CYCLES - 1)) begin
					state_nxt = RSS_ST_START;
				end else begin
					init_nxt = init_r + 13'h0001;
				end
			end
			RSS_ST_START: begin
				if (timer_done) begin
					state_nxt = RSS_ST_RUN;
					cold_nxt  = 1'b0;
				end
			end
			RSS_ST_RUN: begin
				if (wake_req) begin
					state_nxt = RSS_ST_START;
				end
			end
			default: state_nxt = RSS_ST_RESET;
		endcase
		if (mon.por_low) begin
			state_nxt = RSS_ST_RESET;
			cold_nxt  = 1'b1;
		end else if (brn_act) begin
			state_nxt = RSS_ST_RESET;
		end
	end

	// Power-up starts as a cold start.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= RSS_ST_RESET;
			init_r  <= 13'h0000;
			cold_r  <= 1'b1;
		end else begin
			state_r <= state_nxt;
			init_r  <= init_nxt;
			cold_r  <= cold_nxt;
		end
	end

	// ==========================================================================
	// Software and watchdog reset pulses
	// ==========================================================================
	// A fixed-length pulse keeps the core in reset long enough to settle.
	always_comb begin
		pulse_nxt = pulse_r;
		if (sw_req || wd_req) begin
			pulse_nxt = 5'(PULSE_CYCLES);
		end else if (pulse_r != 5'h00) begin
			pulse_nxt = pulse_r - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pulse_r <= 5'h00;
		end else begin
			pulse_r <= pulse_nxt;
		end
	end

	// ==========================================================================
	// Reset outputs
	// ==========================================================================
	logic rst_nxt;

	// Pin counts only when enabled, except during power-up.
	always_comb begin
		rst_nxt = (state_r != RSS_ST_RUN) || (pulse_r != 5'h00);
		if (mon.pin_low && (fuses.ext_en || cold_r)) begin
			rst_nxt = 1'b1;
		end
	end

	// Registered release keeps reset aligned to the system clock.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sys_reset <= 1'b1;
			port_oe_n <= 1'b1;
			pc_start  <= RESET_VECTOR;
		end else begin
			sys_reset <= rst_nxt;
			port_oe_n <= rst_nxt;
			pc_start  <= RESET_VECTOR;
		end
	end

	// ==========================================================================
	// Register bus
	// ==========================================================================
	logic [7:0] power_control_reg_r;
	logic [7:0] power_control_reg_nxt;
	logic       bvalid_nxt;
	logic       rvalid_nxt;
	logic [31:0] rdata_nxt;
	logic [1:0] bresp_nxt;
	logic [1:0] rresp_nxt;
	logic       wr_go;
	logic       rd_go;

	// Both write channels are taken together once no response waits.
	assign s_awready = s_awvalid && s_wvalid && !s_bvalid;
	assign s_wready  = s_awready;
	assign s_arready = !s_rvalid;
	assign wr_go     = s_awready;
	assign rd_go     = s_arvalid && s_arready;
	assign sw_req    = wr_go && (s_awaddr == ADDR_CTRL) && s_wstrb[0] && s_wdata[CTRL_SOFT_BIT];
	assign wd_req    = wr_go && (s_awaddr == ADDR_CTRL) && s_wstrb[0] && s_wdata[CTRL_WDOG_BIT];

	// Power-off flag: set wins over a software clear in the same cycle.
	always_comb begin
		power_control_reg_nxt = power_control_reg_r;
		bvalid_nxt = s_bvalid && !s_bready;
		bresp_nxt  = s_bresp;
		rvalid_nxt = s_rvalid && !s_rready;
		rdata_nxt  = s_rdata;
		rresp_nxt  = s_rresp;
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = 2'b00;
			if (s_awaddr == ADDR_PWR) begin
				if (s_wstrb[0]) begin
					power_control_reg_nxt = s_wdata[7:0];
				end
			end else if (s_awaddr != ADDR_CTRL) begin
				bresp_nxt = 2'b10;
			end
		end
		if (cold_r) begin
			power_control_reg_nxt[PWR_OFF_BIT] = 1'b1;
		end
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'b00;
			case (s_araddr)
				ADDR_CTRL:   rdata_nxt = 32'h0000_0000;
				ADDR_STATUS: rdata_nxt = {26'h0, cold_r, sys_reset, state_r};
				ADDR_PWR:    rdata_nxt = {24'h0, power_control_reg_r};
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = 2'b10;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_control_reg_r <= PWR_RESET;
			s_bvalid <= 1'b0;
			s_bresp  <= 2'b00;
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= 2'b00;
		end else begin
			power_control_reg_r <= power_control_reg_nxt;
			s_bvalid <= bvalid_nxt;
			s_bresp  <= bresp_nxt;
			s_rvalid <= rvalid_nxt;
			s_rdata  <= rdata_nxt;
			s_rresp  <= rresp_nxt;
		end
	end

endmodule

/* File: include/rss_pkg.sv */
// Purpose: Shared constants and types for the reset start-up sequencer.
// Assumes: 50 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Times are kept in their own units; cycle counts are derived here.
package rss_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned INIT_TIME_US   = 143;
	localparam int unsigned INIT_CYCLES    = INIT_TIME_US * CLK_MHZ;
	localparam int unsigned US_TICK_CYCLES = CLK_MHZ;
	localparam int unsigned PULSE_CYCLES   = 16;
	localparam logic [15:0] RESET_VECTOR   = 16'h0000;

	// Start-up delays in microseconds, indexed by fuse code.
	localparam int unsigned DLY_RC_US0 = 16;
	localparam int unsigned DLY_RC_US1 = 512;
	localparam int unsigned DLY_RC_US2 = 1024;
	localparam int unsigned DLY_RC_US3 = 4096;
	localparam int unsigned DLY_XT_US0 = 1024;
	localparam int unsigned DLY_XT_US1 = 2048;
	localparam int unsigned DLY_XT_US2 = 4096;
	localparam int unsigned DLY_XT_US3 = 16384;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_PWR    = 4'h8;
	localparam int unsigned CTRL_SOFT_BIT  = 0;
	localparam int unsigned CTRL_WDOG_BIT  = 1;
	localparam int unsigned PWR_OFF_BIT    = 4;
	localparam logic [7:0] PWR_RESET       = 8'h00;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [3:0] {
		RSS_ST_RESET = 4'b0001,
		RSS_ST_INIT  = 4'b0010,
		RSS_ST_START = 4'b0100,
		RSS_ST_RUN   = 4'b1000
	} rss_state_e;

	typedef struct packed {
		logic       ext_en;
		logic       brn_en;
		logic       xtal;
		logic [1:0] startup_time_fuses;
	} rss_fuse_s;

	typedef struct packed {
		logic por_low;
		logic brn_low;
		logic pin_low;
	} rss_mon_s;

endpackage

/* File: rtl/rss_sync.sv */
// Purpose: Two-flop synchroniser for a vector of asynchronous levels.
// Assumes: Inputs are quasi-static levels from monitors or pins.
// Notes:   Stage one is read only by stage two.
`timescale 1ns/1ns
module rss_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ==========================================================================
	// Synchroniser
	// ==========================================================================
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	// Each stage takes the one before it.
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// Reset to all ones: monitors read as faulted until sampled.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r   <= '1;
			sync_out <= '1;
		end else begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end

endmodule

/* File: rtl/rss_startup_timer.sv */
// Purpose: Start-up timer counting microsecond ticks to a fuse-chosen limit.
// Assumes: tick is a one-cycle pulse each microsecond.
// Notes:   Clearing run restarts the count from zero.
`timescale 1ns/1ns
module rss_startup_timer
	import rss_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Control
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic       xtal,
	input  wire logic [1:0] startup_time_fuses,
	// Status
	output logic            done
);

	// ==========================================================================
	// Counter
	// ==========================================================================
	logic [14:0] cnt_r;
	logic [14:0] cnt_nxt;
	logic        done_nxt;
	logic [14:0] limit;

	// Terminal count from fuse code and clock source.
	always_comb begin
		case ({xtal, startup_time_fuses})
			3'b000:  limit = 15'(DLY_RC_US0 - 1);
			3'b001:  limit = 15'(DLY_RC_US1 - 1);
			3'b010:  limit = 15'(DLY_RC_US2 - 1);
			3'b011:  limit = 15'(DLY_RC_US3 - 1);
			3'b100:  limit = 15'(DLY_XT_US0 - 1);
			3'b101:  limit = 15'(DLY_XT_US1 - 1);
			3'b110:  limit = 15'(DLY_XT_US2 - 1);
			default: limit = 15'(DLY_XT_US3 - 1);
		endcase
	end

	// Count ticks while running; done holds until run drops.
	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = done;
		if (!run) begin
			cnt_nxt  = '0;
			done_nxt = 1'b0;
		end else if (tick && !done) begin
			if (cnt_r == limit) begin
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 15'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			done  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done  <= done_nxt;
		end
	end

endmodule

/* File: tb/rss_properties.sv */
// Purpose: Timing checks on the reset sequencer ports.
// Assumes: One clock domain; fuses stay static around each check.
// Notes:   Counters measure the long spans that repetition cannot.
`timescale 1ns/1ns
module rss_properties
	import rss_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Monitors and configuration
	input wire logic        por_low,
	input wire logic        brownout_detector,
	input wire logic        reset_pin_n,
	input wire rss_fuse_s   fuses,
	input wire logic        wake_req,
	// Reset outputs
	input wire logic        sys_reset,
	input wire logic        port_oe_n,
	input wire logic [15:0] pc_start
);
	// ==========================================================
	// Helpers
	logic [15:0] up_r;
	logic [15:0] up_nxt;
	logic [15:0] ok_r;
	logic [15:0] ok_nxt;
	// Cycles since each supply level was last low; they saturate so a long run never wraps.
	always_comb begin
		up_nxt = por_low ? 16'h0000 : up_r + {15'h0000, up_r != 16'hffff};
		ok_nxt = brownout_detector ? 16'h0000 : ok_r + {15'h0000, ok_r != 16'hffff};
	end
	// Counter registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			up_r <= 16'h0000;
			ok_r <= 16'h0000;
		end else begin
			up_r <= up_nxt;
			ok_r <= ok_nxt;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_oe; port_oe_n == sys_reset; endproperty
	a_oe: assert property (p_oe) else $error("port tristate differs from reset");
	property p_pc; pc_start == 16'h0000; endproperty
	a_pc: assert property (p_pc) else $error("start address not zero");
	property p_por_hold; por_low [*5] |-> sys_reset; endproperty
	a_por_hold: assert property (p_por_hold) else $error("reset low with supply low");
	property p_por_fast; $rose(por_low) |-> ##[1:4] sys_reset; endproperty
	a_por_fast: assert property (p_por_fast) else $error("supply loss not acted on");
	property p_init; $fell(sys_reset) |-> up_r >= INIT_CYCLES; endproperty
	a_init: assert property (p_init) else $error("release before init time");
	property p_brn_fast; $rose(brownout_detector) && fuses[3] |-> ##[1:4] sys_reset; endproperty
	a_brn_fast: assert property (p_brn_fast) else $error("brown-out not acted on");
	property p_brn_off;
		$rose(brownout_detector) && !fuses[3] && !sys_reset && !por_low && reset_pin_n && !wake_req
			|-> !sys_reset [*4];
	endproperty
	a_brn_off: assert property (p_brn_off) else $error("disabled brown-out reset");
	property p_pin; (fuses[4] && !reset_pin_n) [*4] |-> sys_reset; endproperty
	a_pin: assert property (p_pin) else $error("reset low with pin low");
	property p_brn_rel; $fell(sys_reset) && fuses[3] |-> ok_r >= 16'd750; endproperty
	a_brn_rel: assert property (p_brn_rel) else $error("release before start-up delay");
	// Main scenarios reached.
	c_cold: cover property ($fell(sys_reset) && up_r < 16'd9000);
	c_brn: cover property ($rose(brownout_detector) && fuses[3]);
	c_pin: cover property (!reset_pin_n && sys_reset);
endmodule
bind rss_top rss_properties i_rss_properties (
	.clk              (clk),
	.resetn           (resetn),
	.por_low          (por_low),
	.brownout_detector(brownout_detector),
	.reset_pin_n      (reset_pin_n),
	.fuses            (fuses),
	.wake_req         (wake_req),
	.sys_reset        (sys_reset),
	.port_oe_n        (port_oe_n),
	.pc_start         (pc_start)
);

/* File: tb/rss_supply_model.sv */
// Purpose: Supply monitors and reset pin in front of the sequencer.
// Assumes: Supply given in millivolts by the bench.
// Notes:   Pin has a pull-up, so it reads high when released.
`timescale 1ns/1ns
module rss_supply_model #(
	parameter int unsigned POR_MV   = 1400,
	parameter int unsigned BROWN_MV = 2000,
	parameter int unsigned HYST_MV  = 200
) (
	// Clock
	input wire logic        clk,
	// Stimulus
	input wire logic [15:0] vdd_mv,
	input wire logic        pin_req,
	// Monitor outputs
	output logic            por_low,
	output logic            brownout_detector,
	output logic            reset_pin_n
);
	logic [1:0] hold_r = 2'd0;
	// Power-on level has no hysteresis.
	assign por_low = vdd_mv < POR_MV;
	// Hysteresis stops chatter near the trigger level.
	initial brownout_detector = 1'b1;
	always @(posedge clk) begin
		if (vdd_mv < BROWN_MV)
			brownout_detector <= 1'b1;
		else if (vdd_mv > BROWN_MV + HYST_MV)
			brownout_detector <= 1'b0;
	end
	// Any request keeps the pin low two more cycles, so no pulse is too short.
	always @(posedge clk) hold_r <= pin_req ? 2'd2 : hold_r - {1'b0, hold_r != 2'd0};
	assign reset_pin_n = !(pin_req || hold_r != 2'd0);
endmodule

/* File: tb/rss_top_tb_top.sv */
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Fuse code 00 keeps most delays short.
// Notes:   Delays allow one tick of slack for the free-running time base.
`timescale 1ns/1ns
module rss_top_tb_top
	import rss_pkg::*;
;
	logic        clk, resetn, wake_req, pin_req, sys_reset, port_oe_n;
	logic        por_low, brownout_detector, reset_pin_n;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	logic [15:0] vdd_mv, pc_start;
	logic [3:0]  s_awaddr, s_wstrb, s_araddr;
	logic [31:0] s_wdata, s_rdata, rdat;
	logic [1:0]  s_bresp, s_rresp, rsp;
	rss_fuse_s   fuses;
	int          miscompares, n_compared, seed, n, r;
	localparam logic [3:0] PWR_ADDR = 4'h8;
	localparam int         T_US[8]  = '{16, 512, 1024, 4096, 1024, 2048, 4096, 16384};
	localparam logic [4:0] F[3]     = '{5'b11000, 5'b11001, 5'b11100};
	// ==========================================================
	// Design and partner
	rss_top i_rss_top (.clk(clk), .resetn(resetn), .por_low(por_low), .brownout_detector(brownout_detector),
		.reset_pin_n(reset_pin_n), .fuses(fuses), .wake_req(wake_req), .sys_reset(sys_reset),
		.port_oe_n(port_oe_n), .pc_start(pc_start), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready));
	rss_supply_model i_rss_supply_model (.clk(clk), .vdd_mv(vdd_mv), .pin_req(pin_req), .por_low(por_low),
		.brownout_detector(brownout_detector), .reset_pin_n(reset_pin_n));
	// ==========================================================
	// Helpers
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// Address and data go out together; each is dropped on its own acceptance.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && s_awready === 1'b1) begin
				aw = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w && s_wready === 1'b1) begin
				w = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		while (s_bvalid !== 1'b1) @(posedge clk);
		s_bready <= 1'b0;
		rsp = s_bresp;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge clk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		while (s_rvalid !== 1'b1) @(posedge clk);
		s_rready <= 1'b0;
		rdat = s_rdata;
		rsp = s_rresp;
	endtask
	// Cycles until reset falls, bounded so a stuck reset cannot hang.
	task automatic rel();
		n = 0;
		while (sys_reset !== 1'b0 && n < 60000) begin
			@(posedge clk);
			n++;
		end
	endtask
	function automatic int exp_cyc(input logic x, input logic [1:0] c);
		return T_US[{x, c}] * CLK_MHZ;
	endfunction
	function automatic logic near(input int a, input int b);
		return (a > b - 60) && (a < b + 60);
	endfunction
	task automatic wrap_up();
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog: a clean run needs about 87000 cycles, so 98000 leaves margin.
	initial begin
		cyc(98000);
		miscompares++;
		wrap_up();
	end
	// ==========================================================
	// Scenarios
	initial begin
		{miscompares, n_compared, seed} = {32'sd0, 32'sd0, 32'sd81422};
		{resetn, wake_req, pin_req, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 8'h00;
		{s_awaddr, s_wstrb, s_araddr, s_wdata} = 44'h0;
		vdd_mv = 16'd0;
		fuses = 5'b11000;
		cyc(8);
		resetn <= 1'b1;
		cyc(20);
		chk(sys_reset === 1'b1 && port_oe_n === 1'b1 && pc_start === 16'h0000, "reset outputs");
		vdd_mv <= 16'd3300;
		rel();
		chk(near(n, INIT_CYCLES + exp_cyc(1'b0, 2'b00)), "cold start length");
		axi_rd(PWR_ADDR);
		chk(rdat[4] === 1'b1, "cold flag");
		axi_rd(4'h4);
		chk(rdat[5:0] === 6'h08, "run state");
		r = $random(seed);
		axi_wr(PWR_ADDR, r & 32'hff);
		chk(rsp === 2'b00, "write response");
		axi_rd(PWR_ADDR);
		chk(rdat[7:0] === r[7:0], "flag register write");
		axi_wr(PWR_ADDR, 32'h0);
		// Brown-out recovery for two oscillator codes and one crystal code.
		for (int i = 0; i < 3; i++) begin
			fuses <= F[i];
			cyc(2);
			vdd_mv <= 16'd1900;
			cyc(6);
			chk(sys_reset === 1'b1, "brown-out entry");
			cyc(100);
			vdd_mv <= 16'd3300;
			rel();
			chk(near(n, exp_cyc(F[i][2], F[i][1:0])), "brown-out delay");
		end
		axi_rd(PWR_ADDR);
		chk(rdat[4] === 1'b0, "flag after warm reset");
		fuses <= 5'b10000;
		cyc(2);
		vdd_mv <= 16'd1900;
		cyc(200);
		chk(sys_reset === 1'b0, "disabled brown-out");
		vdd_mv <= 16'd3300;
		cyc(4);
		r = 20 + ($random(seed) & 255);
		pin_req <= 1'b1;
		cyc(r);
		chk(sys_reset === 1'b1, "pin hold");
		pin_req <= 1'b0;
		rel();
		chk(n < 2000, "pin release");
		wake_req <= 1'b1;
		cyc(1);
		wake_req <= 1'b0;
		cyc(4);
		chk(sys_reset === 1'b1, "wake start");
		rel();
		chk(near(n + 5, exp_cyc(1'b0, 2'b00)), "wake delay");
		// Software and watchdog pulses, then a control read-back.
		for (int b = 0; b < 2; b++) begin
			axi_wr(4'h0, 32'h1 << b);
			cyc(2);
			rel();
			chk(n >= 10 && n <= 20, "reset pulse length");
		end
		axi_rd(4'h0);
		chk(rdat === 32'h0, "control reads zero");
		axi_rd(4'hc);
		chk(rsp === 2'b10 && rdat === 32'h0, "unmapped read");
		axi_wr(4'hc, 32'h0);
		chk(rsp === 2'b10, "unmapped write");
		vdd_mv <= 16'd1000;
		cyc(5);
		chk(sys_reset === 1'b1, "supply loss");
		wrap_up();
	end
endmodule
